// file: verilog/drps_device.sv
`timescale 1ns/10ps
// ==========================================================
// display end: reset filter, blanking, OTP load, sleep state
module drps_device #(
  parameter int unsigned DONE_IN_CYCLES  = drps_pkg::DONE_IN_CYC,
  parameter int unsigned DONE_OUT_CYCLES = drps_pkg::DONE_OUT_CYC
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_rst,
  drps_if.device                               link,
  input  wire logic [drps_pkg::OTP_W-1:0]      i_otp_word,
  output logic      [$clog2(drps_pkg::OTP_WORDS)-1:0] o_otp_addr,
  output logic      [drps_pkg::OTP_W-1:0]      o_reg [drps_pkg::OTP_WORDS],
  output logic                                 o_blank,
  output logic                                 o_busy,
  output logic                                 o_sleep_out,
  output logic                                 o_display_on,
  output logic                                 o_full_reset
);
  import drps_pkg::*;

  typedef enum logic [1:0] {
    DRPS_RUN   = 2'b00,
    DRPS_HELD  = 2'b01,
    DRPS_LOAD  = 2'b10
  } drps_state_t;

  // otp address width
  localparam int unsigned AW = $clog2(OTP_WORDS);

  // ==========================================================
  // pin synchroniser; both flops preset high, the pin's idle level,
  // so leaving reset never shows a false low
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end
    else
    begin
      rst_meta_q <= link.reset_n;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // pulse width, sequence state
  drps_state_t        state_q, state_d;
  logic [CNT_W-1:0]   low_q, low_d;
  logic [CNT_W-1:0]   hi_q, hi_d;
  logic [CNT_W-1:0]   tmr_q, tmr_d;
  logic [AW-1:0]      addr_q, addr_d;
  logic               slp_q, slp_d;
  logic               don_q, don_d;
  logic               full_q, full_d;
  logic               was_out_q, was_out_d;
  logic [OTP_W-1:0]   reg_q [OTP_WORDS];
  logic               wr_en;
  logic               rel;

  // next-state logic; run lengths of both pin levels feed one sequence
  always_comb
  begin
    state_d   = state_q;
    low_d     = low_q;
    tmr_d     = tmr_q;
    addr_d    = addr_q;
    slp_d     = slp_q;
    don_d     = don_q;
    full_d    = full_q;
    was_out_d = was_out_q;
    hi_d      = hi_q;
    wr_en     = 1'b0;
    // high run length; a release only counts once it outlasts the
    // reject width, so a high spike cannot cut a held reset short
    if (rst_sync_q && hi_q != CNT_W'(REJECT_CYC))
      hi_d = hi_q + CNT_W'(1);
    else if (!rst_sync_q)
      hi_d = '0;
    rel = rst_sync_q && (hi_q == CNT_W'(REJECT_CYC));
    // low run length, saturating at the full-reset width; kept across
    // short high spikes and cleared only by a real release
    if (!rst_sync_q && low_q != CNT_W'(VALID_CYC))
      low_d = low_q + CNT_W'(1);
    else if (rel)
      low_d = '0;
    unique case (state_q)
      DRPS_RUN:
      begin
        // commands act only here; while busy they are dropped
        if (link.cmd_valid)
        begin
          unique case (link.cmd)
            DRPS_CMD_SLEEP_OUT:   slp_d = 1'b1;
            DRPS_CMD_SLEEP_IN:    slp_d = 1'b0;
            DRPS_CMD_DISPLAY_ON:  don_d = 1'b1;
            DRPS_CMD_DISPLAY_OFF: don_d = 1'b0;
          endcase
        end
        // a low run under the reject width, summed across short high spikes, never leaves this state
        if (!rst_sync_q && low_q >= CNT_W'(REJECT_CYC))
        begin
          state_d   = DRPS_HELD;
          was_out_d = slp_q;
          full_d    = 1'b0;
          don_d     = 1'b0;
          tmr_d     = '0;
        end
      end
      DRPS_HELD:
      begin
        // full reset once the low run reaches the valid width
        if (low_q == CNT_W'(VALID_CYC))
          full_d = 1'b1;
        // completion timer runs from reset start, not from release
        if (tmr_q != '1)
          tmr_d = tmr_q + CNT_W'(1);
        if (rel)
        begin
          state_d = DRPS_LOAD;
          addr_d  = '0;
        end
      end
      DRPS_LOAD:
      begin
        // one otp word per cycle, address walking up from zero
        wr_en  = 1'b1;
        addr_d = addr_q + AW'(1);
        if (tmr_q != '1)
          tmr_d = tmr_q + CNT_W'(1);
        if (addr_q == AW'(OTP_WORDS - 1))
        begin
          // stay blank until the mode's completion time is met
          wr_en = 1'b1;
          addr_d = addr_q;
          if (tmr_q >= CNT_W'(was_out_q ? DONE_OUT_CYCLES : DONE_IN_CYCLES))
          begin
            state_d = DRPS_RUN;
            slp_d   = 1'b0;
          end
        end
        // a fresh long low restarts the hold and keeps the mode
        if (!rst_sync_q && low_q >= CNT_W'(REJECT_CYC))
        begin
          state_d = DRPS_HELD;
          tmr_d   = '0;
        end
      end
      // the spare code falls back to run
      default: state_d = DRPS_RUN;
    endcase
  end

  // registers only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q   <= DRPS_RUN;
      low_q     <= '0;
      hi_q      <= CNT_W'(REJECT_CYC); // pin idles released
      tmr_q     <= '0;
      addr_q    <= '0;
      slp_q     <= 1'b0;
      don_q     <= 1'b0;
      full_q    <= 1'b0;
      was_out_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      low_q     <= low_d;
      hi_q      <= hi_d;
      tmr_q     <= tmr_d;
      addr_q    <= addr_d;
      slp_q     <= slp_d;
      don_q     <= don_d;
      full_q    <= full_d;
      was_out_q <= was_out_d;
    end
  end

  // ==========================================================
  // internal registers loaded from OTP, one word per cycle
  for (genvar g = 0; g < OTP_WORDS; g++)
  begin : g_reg
    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        reg_q[g] <= '0;
      else if (wr_en && addr_q == AW'(g))
        reg_q[g] <= i_otp_word;
    end
    assign o_reg[g] = reg_q[g];
  end

  // status outputs decoded from registered state
  assign o_otp_addr   = addr_q;
  assign o_blank      = (state_q != DRPS_RUN) || !don_q;
  assign o_busy       = (state_q != DRPS_RUN);
  assign o_sleep_out  = slp_q;
  assign o_display_on = don_q;
  assign o_full_reset = full_q;
endmodule : drps_device

// file: verilog/drps_pkg.sv
package drps_pkg;
  // ==========================================================
  // clock and time base
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned NS_PER_CYCLE  = 20;
  localparam int unsigned REJECT_US     = 5;
  localparam int unsigned VALID_US      = 10;
  localparam int unsigned DONE_IN_MS    = 5;
  localparam int unsigned DONE_OUT_MS   = 120;
  localparam int unsigned CMD_WAIT_MS   = 5;
  localparam int unsigned SLPOUT_WAIT_MS = 120;
  localparam int unsigned SUPPLY_RST_MS = 10;
  localparam int unsigned RST_CMD_MS    = 10;
  localparam int unsigned DISPON_MS     = 60;
  localparam int unsigned SLPIN_RST_MS  = 83;
  // cycle counts: least times round up, longest round down
  localparam int unsigned REJECT_CYC   = (REJECT_US * 1000) / NS_PER_CYCLE;
  localparam int unsigned VALID_CYC    = (VALID_US * 1000 + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned DONE_IN_CYC  = (DONE_IN_MS * 1000) * (1000 / NS_PER_CYCLE);
  localparam int unsigned DONE_OUT_CYC = (DONE_OUT_MS * 1000) * (1000 / NS_PER_CYCLE);
  localparam int unsigned CMD_WAIT_CYC = (CMD_WAIT_MS * 1000) * (1000 / NS_PER_CYCLE);
  localparam int unsigned SLPOUT_WAIT_CYC = (SLPOUT_WAIT_MS * 1000) * (1000 / NS_PER_CYCLE);
  localparam int unsigned SUPPLY_RST_CYC = (SUPPLY_RST_MS * 1000) * (1000 / NS_PER_CYCLE);
  localparam int unsigned RST_CMD_CYC  = (RST_CMD_MS * 1000) * (1000 / NS_PER_CYCLE);
  localparam int unsigned DISPON_CYC   = (DISPON_MS * 1000) * (1000 / NS_PER_CYCLE);
  localparam int unsigned SLPIN_RST_CYC = (SLPIN_RST_MS * 1000) * (1000 / NS_PER_CYCLE);
  localparam int unsigned CNT_W        = 24;
  localparam int unsigned OTP_W        = 8;
  localparam int unsigned OTP_WORDS    = 4;
  // ==========================================================
  // display commands
  typedef enum logic [1:0] {
    DRPS_CMD_SLEEP_OUT   = 2'h0,
    DRPS_CMD_DISPLAY_ON  = 2'h1,
    DRPS_CMD_DISPLAY_OFF = 2'h2,
    DRPS_CMD_SLEEP_IN    = 2'h3
  } drps_cmd_t;
endpackage : drps_pkg

// file: verilog/drps_if.sv
`timescale 1ns/10ps
// ==========================================================
// reset pin, command strobe, link low-power flag
interface drps_if;
  logic                     reset_n;
  logic                     cmd_valid;
  drps_pkg::drps_cmd_t      cmd;
  logic                     link_ulp;
  modport host   (output reset_n, output cmd_valid, output cmd, output link_ulp);
  modport device (input reset_n, input cmd_valid, input cmd, input link_ulp);
endinterface : drps_if

// file: verilog/drps_host.sv
`timescale 1ns/10ps
// ==========================================================
// host end: power-up and power-down command sequencer
module drps_host #(
  parameter int unsigned SUPPLY_RST_CYCLES = drps_pkg::SUPPLY_RST_CYC,
  parameter int unsigned RST_CMD_CYCLES    = drps_pkg::RST_CMD_CYC,
  parameter int unsigned SLPOUT_CYCLES     = drps_pkg::SLPOUT_WAIT_CYC,
  parameter int unsigned DISPON_CYCLES     = drps_pkg::DISPON_CYC,
  parameter int unsigned SLPIN_RST_CYCLES  = drps_pkg::SLPIN_RST_CYC,
  parameter int unsigned RST_LOW_CYCLES    = drps_pkg::VALID_CYC
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  input  wire logic  i_logic_supply_ok,
  input  wire logic  i_power_up,
  input  wire logic  i_power_down,
  drps_if.host       link,
  output logic       o_analog_supply_en,
  output logic       o_up,
  output logic       o_off
);
  import drps_pkg::*;

  typedef enum logic [2:0] {
    DRPS_H_OFF     = 3'b000,
    DRPS_H_PULSE   = 3'b001,
    DRPS_H_WAIT    = 3'b010,
    DRPS_H_SLPOUT  = 3'b011,
    DRPS_H_DISPON  = 3'b100,
    DRPS_H_ON      = 3'b101,
    DRPS_H_SLPIN   = 3'b110,
    DRPS_H_DOWN    = 3'b111
  } drps_hstate_t;

  drps_hstate_t       st_q, st_d;
  logic [CNT_W-1:0]   t_q, t_d;
  logic               rst_n_q, rst_n_d;
  logic               cv_q, cv_d;
  drps_cmd_t          cmd_q, cmd_d;
  logic               ulp_q, ulp_d;
  logic               ana_q, ana_d;

  // every wait but the supply one (counted from supply good) runs from state entry; the first command waits
  // out both post-reset times, so either may be set the longer
  always_comb
  begin
    st_d    = st_q;
    t_d     = t_q + CNT_W'(1);
    rst_n_d = rst_n_q;
    cv_d    = 1'b0;
    cmd_d   = cmd_q;
    ulp_d   = ulp_q;
    ana_d   = ana_q;
    unique case (st_q)
      DRPS_H_OFF:
      begin
        rst_n_d = 1'b0;
        if (!i_logic_supply_ok)
          t_d = '0;
        else if (i_power_up && t_q >= CNT_W'(SUPPLY_RST_CYCLES))
        begin
          st_d  = DRPS_H_PULSE;
          ana_d = 1'b1;
          t_d   = '0;
        end
      end
      DRPS_H_PULSE:
        if (t_q >= CNT_W'(RST_LOW_CYCLES))
        begin
          st_d    = DRPS_H_WAIT;
          rst_n_d = 1'b1;
          ulp_d   = 1'b0;
          t_d     = '0;
        end
      DRPS_H_WAIT:
        if (t_q >= CNT_W'(SLPOUT_CYCLES) && t_q >= CNT_W'(RST_CMD_CYCLES))
        begin
          st_d  = DRPS_H_SLPOUT;
          cv_d  = 1'b1;
          cmd_d = DRPS_CMD_SLEEP_OUT;
          t_d   = '0;
        end
      DRPS_H_SLPOUT:
        if (t_q >= CNT_W'(DISPON_CYCLES))
        begin
          st_d  = DRPS_H_ON;
          cv_d  = 1'b1;
          cmd_d = DRPS_CMD_DISPLAY_ON;
        end
      DRPS_H_ON:
      begin
        t_d = '0;
        if (i_power_down)
        begin
          st_d  = DRPS_H_DISPON;
          cv_d  = 1'b1;
          cmd_d = DRPS_CMD_DISPLAY_OFF;
        end
      end
      DRPS_H_DISPON:
      begin
        st_d  = DRPS_H_SLPIN;
        cv_d  = 1'b1;
        cmd_d = DRPS_CMD_SLEEP_IN;
        t_d   = '0;
      end
      DRPS_H_SLPIN:
        if (t_q >= CNT_W'(SLPIN_RST_CYCLES))
        begin
          st_d    = DRPS_H_DOWN;
          ulp_d   = 1'b1;
          rst_n_d = 1'b0;
        end
      DRPS_H_DOWN:
      begin
        st_d  = DRPS_H_OFF;
        ana_d = 1'b0;
        t_d   = '0;
      end
    endcase
  end

  // registers only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_q    <= DRPS_H_OFF;
      t_q     <= '0;
      rst_n_q <= 1'b0;
      cv_q    <= 1'b0;
      cmd_q   <= DRPS_CMD_SLEEP_OUT;
      ulp_q   <= 1'b1;
      ana_q   <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      t_q     <= t_d;
      rst_n_q <= rst_n_d;
      cv_q    <= cv_d;
      cmd_q   <= cmd_d;
      ulp_q   <= ulp_d;
      ana_q   <= ana_d;
    end
  end

  assign link.reset_n       = rst_n_q;
  assign link.cmd_valid     = cv_q;
  assign link.cmd           = cmd_q;
  assign link.link_ulp      = ulp_q;
  assign o_analog_supply_en = ana_q;
  assign o_up               = (st_q == DRPS_H_ON);
  assign o_off              = (st_q == DRPS_H_OFF);
endmodule : drps_host

// file: testbench/drps_chk.sv
`timescale 1ns/10ps
// ==========================================
// host-side wire rules on the shared link
module drps_chk #(
  parameter int unsigned RST_LOW = 500,
  parameter int unsigned RST_CMD = 200,
  parameter int unsigned SLPOUT  = 300,
  parameter int unsigned DISPON  = 150,
  parameter int unsigned SLPIN   = 120
) (
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire logic                reset_n,
  input wire logic                cmd_valid,
  input wire drps_pkg::drps_cmd_t cmd,
  input wire logic                link_ulp
);
  import drps_pkg::*;
  logic [31:0] low_q, high_q, so_q, si_q;
  logic        off_q, si_seen_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ages of pin levels and commands; 32 bits never wrap in a run
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      low_q     <= '0;
      high_q    <= '0;
      so_q      <= '0;
      si_q      <= '0;
      off_q     <= 1'b0;
      si_seen_q <= 1'b0;
    end
    else
    begin
      low_q     <= reset_n ? '0 : low_q + 1;
      high_q    <= reset_n ? high_q + 1 : '0;
      so_q      <= (cmd_valid && cmd == DRPS_CMD_SLEEP_OUT) ? '0 : so_q + 1;
      si_q      <= (cmd_valid && cmd == DRPS_CMD_SLEEP_IN) ? '0 : si_q + 1;
      off_q     <= cmd_valid ? (cmd == DRPS_CMD_DISPLAY_OFF) : off_q;
      si_seen_q <= (cmd_valid && cmd == DRPS_CMD_SLEEP_IN) ? 1'b1 : (reset_n & si_seen_q);
    end
  end
  AST_RST_WIDTH: assert property ($rose(reset_n) |-> low_q >= RST_LOW)
    else $error("reset pulse too short");
  AST_CMD_IN_RST: assert property (cmd_valid |-> reset_n && $past(reset_n))
    else $error("command while reset low");
  AST_CMD_WAIT: assert property (cmd_valid |-> high_q >= RST_CMD - 1)
    else $error("command too soon after reset");
  AST_SLPOUT_WAIT: assert property (cmd_valid && cmd == DRPS_CMD_SLEEP_OUT |->
    high_q >= SLPOUT - 1) else $error("sleep out too soon");
  AST_DISPON_WAIT: assert property (cmd_valid && cmd == DRPS_CMD_DISPLAY_ON |->
    so_q >= DISPON - 1) else $error("display on too soon");
  AST_OFF_FIRST: assert property (cmd_valid && cmd == DRPS_CMD_SLEEP_IN |-> off_q)
    else $error("sleep in without display off");
  AST_SLPIN_WAIT: assert property ($fell(reset_n) && si_seen_q |-> si_q >= SLPIN - 1)
    else $error("reset low too soon after sleep in");
  AST_ULP_FIRST: assert property ($fell(reset_n) |-> link_ulp)
    else $error("reset low with link awake");
endmodule : drps_chk

// file: testbench/drps_tb_top.sv
`timescale 1ns/10ps
// ==========================================
// bench: host and display ends face to face
module drps_tb_top;
  import drps_pkg::*;
  localparam int SUP  = 100;
  localparam int RCM  = 200;
  localparam int SLO  = 300;
  localparam int DSP  = 150;
  localparam int SLI  = 120;
  localparam int DIN  = 600;
  localparam int DOUT = 1500;
  logic       i_clk = 1'b0;
  logic       i_rst;
  logic       sup, pu, pd, an_en, up, off;
  logic [1:0] a1, a2;
  logic [7:0] r1 [4];
  logic [7:0] r2 [4];
  logic       bl1, bs1, so1, do1, fr1, bl2, bs2, so2, do2, fr2;
  int         num_errors = 0;
  int         total_checks = 0;
  int         cyc = 0;
  drps_if link ();
  drps_if l2 ();
  drps_host #(.SUPPLY_RST_CYCLES(SUP), .RST_CMD_CYCLES(RCM), .SLPOUT_CYCLES(SLO),
    .DISPON_CYCLES(DSP), .SLPIN_RST_CYCLES(SLI)) drps_host_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_logic_supply_ok(sup), .i_power_up(pu),
    .i_power_down(pd), .link(link), .o_analog_supply_en(an_en), .o_up(up), .o_off(off));
  // otp word derived from its address so every slot differs
  drps_device #(.DONE_IN_CYCLES(DIN), .DONE_OUT_CYCLES(DOUT)) drps_device_inst (
    .i_clk(i_clk), .i_rst(i_rst), .link(link), .i_otp_word({6'h28, a1}), .o_otp_addr(a1),
    .o_reg(r1), .o_blank(bl1), .o_busy(bs1), .o_sleep_out(so1), .o_display_on(do1),
    .o_full_reset(fr1));
  // second display end driven by the bench to break host timing on purpose
  drps_device #(.DONE_IN_CYCLES(DIN), .DONE_OUT_CYCLES(DOUT)) drps_device_inst_b (
    .i_clk(i_clk), .i_rst(i_rst), .link(l2), .i_otp_word({6'h28, a2}), .o_otp_addr(a2),
    .o_reg(r2), .o_blank(bl2), .o_busy(bs2), .o_sleep_out(so2), .o_display_on(do2),
    .o_full_reset(fr2));
  drps_chk #(.RST_LOW(VALID_CYC), .RST_CMD(RCM), .SLPOUT(SLO), .DISPON(DSP),
    .SLPIN(SLI)) drps_chk_inst (.i_clk(i_clk), .i_rst(i_rst), .reset_n(link.reset_n),
    .cmd_valid(link.cmd_valid), .cmd(link.cmd), .link_ulp(link.link_ulp));
  always #10 i_clk = ~i_clk;
  // ==========================================
  // helpers
  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // hang guard: whole run needs under 10000 cycles
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tk
  task automatic cmd2(input drps_cmd_t c);
    l2.cmd = c;
    l2.cmd_valid = 1'b1;
    tk(1);
    l2.cmd_valid = 1'b0;
  endtask : cmd2
  // low pulse of n cycles; s = busy seen, d = cycles from fall to busy end
  task automatic p2(input int n, output bit s, output int d);
    s = 0;
    d = 0;
    l2.reset_n = 1'b0;
    for (int c = 1; c < 4000; c++)
    begin
      tk(1);
      if (c == n) l2.reset_n = 1'b1;
      if (bs2 === 1'b1) s = 1;
      if (s && bs2 === 1'b0 && d == 0) d = c;
      if (d != 0 || (!s && c > n + 400)) break;
    end
  endtask : p2
  // ==========================================
  // scenarios
  task automatic t_up();
    int c;
    c = 0;
    sup = 1'b1;
    pu = 1'b1;
    while (link.reset_n !== 1'b1 && c < 3000)
    begin
      tk(1);
      c++;
    end
    chk(c >= SUP, 1);
    while (up !== 1'b1 && c < 6000)
    begin
      tk(1);
      c++;
    end
    // the device takes display on at the edge after the host's on state
    tk(1);
    chk({so1, do1, bl1, fr1}, 4'b1101);
    chk({r1[0], r1[1], r1[2], r1[3]}, 32'hA0A1A2A3);
    $display("power up done");
  endtask : t_up
  task automatic t_down();
    int  c;
    bit  bad;
    c = 0;
    bad = 0;
    pu = 1'b0;
    pd = 1'b1;
    while (off !== 1'b1 && c < 3000)
    begin
      tk(1);
      c++;
      if (an_en === 1'b0 && link.reset_n !== 1'b0) bad = 1;
    end
    chk(bad, 0);
    chk({link.link_ulp, link.reset_n, an_en}, 3'b100);
    tk(10);
    chk({so1, do1, bl1}, 3'b001);
    $display("power down done");
  endtask : t_down
  task automatic t_pulses();
    bit s;
    int d;
    p2(200, s, d);
    chk(s, 0);
    p2(300, s, d);
    chk({s, fr2}, 2'b10);
    // completion bound counts from the rising edge of the pin
    chk(d > 300 + OTP_WORDS && d <= 300 + DIN + 8, 1);
    chk({r2[0], r2[1], r2[2], r2[3]}, 32'hA0A1A2A3);
    chk(bl2, 1);
    // 300 low, 50 high spike, 300 low: one pulse past the full width
    l2.reset_n = 1'b0;
    tk(300);
    l2.reset_n = 1'b1;
    tk(50);
    p2(300, s, d);
    chk({s, fr2}, 2'b11);
    $display("reset pulses done");
  endtask : t_pulses
  task automatic t_sout();
    bit s;
    int d;
    tk(400);
    cmd2(DRPS_CMD_SLEEP_OUT);
    tk(DSP);
    cmd2(DRPS_CMD_DISPLAY_ON);
    tk(2);
    chk({so2, do2, bl2}, 3'b110);
    p2(520, s, d);
    chk(d > 520 + DIN && d <= 520 + DOUT + 8, 1);
    chk({so2, do2, bl2}, 3'b001);
    $display("sleep-out reset done");
  endtask : t_sout
  initial
  begin
    i_rst = 1'b1;
    sup = 1'b0;
    pu = 1'b0;
    pd = 1'b0;
    l2.reset_n = 1'b1;
    l2.cmd_valid = 1'b0;
    l2.cmd = DRPS_CMD_SLEEP_OUT;
    l2.link_ulp = 1'b0;
    tk(20);
    i_rst = 1'b0;
    t_up();
    t_down();
    t_pulses();
    t_sout();
    results();
  end
endmodule : drps_tb_top
